// >>> verilog/htr_pkg.sv
// Constants and types shared by the humidity and temperature readout target
package htr_pkg;

  // ----------------------------------------
  // Bus addressing and commands
  // ----------------------------------------
  localparam logic [6:0] TARGET_ADDR = 7'h38;
  localparam logic [7:0] CMD_STATUS = 8'h71;
  localparam logic [7:0] CMD_TRIGGER = 8'hAC;
  localparam logic [7:0] TRIG_PARAM1 = 8'h33;
  localparam logic [7:0] TRIG_PARAM2 = 8'h00;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;

  // ----------------------------------------
  // Status byte layout
  // ----------------------------------------
  localparam int STAT_BUSY_BIT = 7;
  localparam int STAT_CAL_BIT = 3;
  localparam logic [7:0] STAT_CAL_MASK = 8'h18;

  // ----------------------------------------
  // Checksum
  // ----------------------------------------
  localparam logic [7:0] CRC_INIT = 8'hFF;
  localparam logic [7:0] CRC_POLY = 8'h31;
  localparam logic [2:0] CRC_IDX = 3'h6;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int POWERUP_MS = 100;
  localparam int MEAS_MS = 80;
  localparam int POWERUP_CYCLES = POWERUP_MS * CLK_MHZ * 1000;
  localparam int MEAS_CYCLES = MEAS_MS * CLK_MHZ * 1000;
  localparam int CNT_W = 25;

  // ----------------------------------------
  // Link state machine
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK,
    ST_WRITE,
    ST_READ,
    ST_RDACK,
    ST_IGNORE
  } htr_state_t;

endpackage : htr_pkg

// >>> verilog/htr_crc8.sv
// One byte step of the checksum over a data byte
`timescale 1ns/10ps

module htr_crc8 (
  // Running value in
  input wire logic [7:0] crc_in,
  // Byte to fold in
  input wire logic [7:0] data_in,
  // Updated value
  output logic [7:0] crc_out
);

  logic [7:0] c;

  always_comb begin
    c = crc_in ^ data_in;
    for (int i = 0; i < 8; i++) begin
      if (c[7]) begin
        c = {c[6:0], 1'b0} ^ htr_pkg::CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    crc_out = c;
  end

endmodule : htr_crc8

// >>> verilog/htr_readout.sv
// Two-wire target that serves status, raw humidity and temperature, and checksum
`timescale 1ns/10ps

// Notes on behaviour
// - Data falling with clock high starts transfer
// - Data rising with clock high stops transfer
// - First byte: address 0x38 plus direction
// - Target pulls data low in acknowledge slot
// - Status: bit 7 busy, bit 3 calibrated
// - Host waits, polls busy, then reads six
// - Seventh byte offered is the checksum
// - Checksum: CRC-8, init 0xFF, poly 0x31
module htr_readout #(
  parameter int POWERUP_CYCLES = htr_pkg::POWERUP_CYCLES,
  parameter int MEAS_CYCLES = htr_pkg::MEAS_CYCLES
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // Serial clock pin
  input wire logic SCL_IN,
  output logic SCL_OUT,
  output logic SCL_OE,
  // Serial data pin
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  // Measurement source
  input wire logic [19:0] HUMIDITY_RAW,
  input wire logic [19:0] TEMPERATURE_RAW,
  input wire logic CALIBRATED,
  // Status
  output logic READY,
  output logic BUSY,
  output logic MEASURE_START
);

  // ----------------------------------------
  // Byte selection for reads
  // ----------------------------------------
  function automatic logic [7:0] read_byte(
    input logic [2:0] idx,
    input logic [7:0] status,
    input logic [19:0] hum,
    input logic [19:0] tmp,
    input logic [7:0] crc
  );
    logic [7:0] b;
    b = htr_pkg::IDLE_BYTE;
    unique case (idx)
      3'h0: b = status;
      3'h1: b = hum[19:12];
      3'h2: b = hum[11:4];
      3'h3: b = {hum[3:0], tmp[19:16]};
      3'h4: b = tmp[15:8];
      3'h5: b = tmp[7:0];
      3'h6: b = crc;
      3'h7: b = htr_pkg::IDLE_BYTE;
    endcase
    return b;
  endfunction : read_byte

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic scl_m_reg, scl_s_reg, scl_q_reg;
  logic sda_m_reg, sda_s_reg, sda_q_reg;
  htr_pkg::htr_state_t state_reg, state_next;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] tx_reg, tx_next;
  logic is_read_reg, is_read_next;
  logic acked_reg, acked_next;
  logic [2:0] rd_idx_reg, rd_idx_next;
  logic [1:0] wr_idx_reg, wr_idx_next;
  logic trig_ok_reg, trig_ok_next;
  logic sda_oe_reg, sda_oe_next;
  logic [7:0] crc_reg, crc_next;
  logic busy_reg, busy_next;
  logic ready_reg, ready_next;
  logic start_reg, start_next;
  logic [htr_pkg::CNT_W-1:0] pwr_cnt_reg, pwr_cnt_next;
  logic [htr_pkg::CNT_W-1:0] meas_cnt_reg, meas_cnt_next;
  logic [19:0] hum_reg, hum_next;
  logic [19:0] tmp_reg, tmp_next;

  logic scl_rise, scl_fall, bus_start, bus_stop;
  logic load_tx, trig_fire;
  logic [7:0] status_byte, next_byte, crc_step;

  // Edges only from the second stage onward, never the first
  assign scl_rise = scl_s_reg && !scl_q_reg;
  assign scl_fall = !scl_s_reg && scl_q_reg;
  assign bus_start = scl_s_reg && scl_q_reg && sda_q_reg && !sda_s_reg;
  assign bus_stop = scl_s_reg && scl_q_reg && !sda_q_reg && sda_s_reg;

  always_comb begin
    status_byte = 8'h00;
    status_byte[htr_pkg::STAT_BUSY_BIT] = busy_reg;
    status_byte[htr_pkg::STAT_CAL_BIT] = CALIBRATED;
  end

  assign next_byte = read_byte(rd_idx_reg, status_byte, hum_reg, tmp_reg, crc_reg);

  htr_crc8 htr_crc8_inst (
    .crc_in(crc_reg),
    .data_in(next_byte),
    .crc_out(crc_step)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    tx_next = tx_reg;
    is_read_next = is_read_reg;
    acked_next = acked_reg;
    rd_idx_next = rd_idx_reg;
    wr_idx_next = wr_idx_reg;
    trig_ok_next = trig_ok_reg;
    sda_oe_next = sda_oe_reg;
    crc_next = crc_reg;
    busy_next = busy_reg;
    ready_next = ready_reg;
    start_next = 1'b0;
    pwr_cnt_next = pwr_cnt_reg;
    meas_cnt_next = meas_cnt_reg;
    hum_next = hum_reg;
    tmp_next = tmp_reg;
    load_tx = 1'b0;
    trig_fire = 1'b0;

    // Power-up delay; no address is answered before it ends
    if (!ready_reg) begin
      if (pwr_cnt_reg == htr_pkg::CNT_W'(POWERUP_CYCLES - 1)) begin
        ready_next = 1'b1;
      end else begin
        pwr_cnt_next = pwr_cnt_reg + 1'b1;
      end
    end

    if (bus_stop) begin
      state_next = htr_pkg::ST_IDLE;
      sda_oe_next = 1'b0;
    end else if (bus_start) begin
      state_next = htr_pkg::ST_ADDR;
      bit_cnt_next = 4'h0;
      wr_idx_next = 2'h0;
      trig_ok_next = 1'b0;
      sda_oe_next = 1'b0;
    end else begin
      unique case (state_reg)
        htr_pkg::ST_IDLE, htr_pkg::ST_IGNORE: begin
          sda_oe_next = 1'b0;
        end
        htr_pkg::ST_ADDR, htr_pkg::ST_WRITE: begin
          if (scl_rise) begin
            shift_next = {shift_reg[6:0], sda_s_reg};
            bit_cnt_next = bit_cnt_reg + 1'b1;
          end
          if (scl_fall && bit_cnt_reg == 4'h8) begin
            bit_cnt_next = 4'h0;
            if (state_reg == htr_pkg::ST_ADDR) begin
              if (shift_reg[7:1] == htr_pkg::TARGET_ADDR && ready_reg) begin
                sda_oe_next = 1'b1;
                is_read_next = shift_reg[0];
                rd_idx_next = 3'h0;
                crc_next = htr_pkg::CRC_INIT;
                state_next = htr_pkg::ST_ACK;
              end else begin
                state_next = htr_pkg::ST_IGNORE;
              end
            end else begin
              sda_oe_next = 1'b1;
              state_next = htr_pkg::ST_ACK;
              unique case (wr_idx_reg)
                2'h0: trig_ok_next = (shift_reg == htr_pkg::CMD_TRIGGER);
                2'h1: trig_ok_next = trig_ok_reg && (shift_reg == htr_pkg::TRIG_PARAM1);
                2'h2: trig_fire = trig_ok_reg && (shift_reg == htr_pkg::TRIG_PARAM2);
                2'h3: trig_ok_next = 1'b0;
              endcase
              if (wr_idx_reg != 2'h3) begin
                wr_idx_next = wr_idx_reg + 1'b1;
              end
            end
          end
        end
        htr_pkg::ST_ACK: begin
          if (scl_fall) begin
            if (is_read_reg) begin
              load_tx = 1'b1;
            end else begin
              sda_oe_next = 1'b0;
              state_next = htr_pkg::ST_WRITE;
            end
          end
        end
        htr_pkg::ST_READ: begin
          if (scl_fall) begin
            if (bit_cnt_reg == 4'h7) begin
              sda_oe_next = 1'b0;
              state_next = htr_pkg::ST_RDACK;
            end else begin
              tx_next = {tx_reg[6:0], 1'b0};
              sda_oe_next = !tx_reg[6];
              bit_cnt_next = bit_cnt_reg + 1'b1;
            end
          end
        end
        htr_pkg::ST_RDACK: begin
          if (scl_rise) begin
            acked_next = !sda_s_reg;
          end
          if (scl_fall) begin
            if (acked_reg) begin
              load_tx = 1'b1;
            end else begin
              state_next = htr_pkg::ST_IGNORE;
            end
          end
        end
      endcase
    end

    // Next read byte goes out right after the falling edge
    if (load_tx) begin
      tx_next = next_byte;
      sda_oe_next = !next_byte[7];
      bit_cnt_next = 4'h0;
      state_next = htr_pkg::ST_READ;
      if (rd_idx_reg < htr_pkg::CRC_IDX) begin
        crc_next = crc_step;
      end
      if (rd_idx_reg != 3'h7) begin
        rd_idx_next = rd_idx_reg + 1'b1;
      end
    end

    // Conversion timer; a trigger while busy is dropped
    if (busy_reg) begin
      if (meas_cnt_reg == htr_pkg::CNT_W'(MEAS_CYCLES - 1)) begin
        busy_next = 1'b0;
        hum_next = HUMIDITY_RAW;
        tmp_next = TEMPERATURE_RAW;
      end else begin
        meas_cnt_next = meas_cnt_reg + 1'b1;
      end
    end else if (trig_fire) begin
      busy_next = 1'b1;
      meas_cnt_next = '0;
      start_next = 1'b1;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      scl_m_reg <= 1'b1;
      scl_s_reg <= 1'b1;
      scl_q_reg <= 1'b1;
      sda_m_reg <= 1'b1;
      sda_s_reg <= 1'b1;
      sda_q_reg <= 1'b1;
      state_reg <= htr_pkg::ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      is_read_reg <= 1'b0;
      acked_reg <= 1'b0;
      rd_idx_reg <= 3'h0;
      wr_idx_reg <= 2'h0;
      trig_ok_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      crc_reg <= htr_pkg::CRC_INIT;
      busy_reg <= 1'b0;
      ready_reg <= 1'b0;
      start_reg <= 1'b0;
      pwr_cnt_reg <= '0;
      meas_cnt_reg <= '0;
      hum_reg <= 20'h0_0000;
      tmp_reg <= 20'h0_0000;
    end else begin
      scl_m_reg <= SCL_IN;
      scl_s_reg <= scl_m_reg;
      scl_q_reg <= scl_s_reg;
      sda_m_reg <= SDA_IN;
      sda_s_reg <= sda_m_reg;
      sda_q_reg <= sda_s_reg;
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      tx_reg <= tx_next;
      is_read_reg <= is_read_next;
      acked_reg <= acked_next;
      rd_idx_reg <= rd_idx_next;
      wr_idx_reg <= wr_idx_next;
      trig_ok_reg <= trig_ok_next;
      sda_oe_reg <= sda_oe_next;
      crc_reg <= crc_next;
      busy_reg <= busy_next;
      ready_reg <= ready_next;
      start_reg <= start_next;
      pwr_cnt_reg <= pwr_cnt_next;
      meas_cnt_reg <= meas_cnt_next;
      hum_reg <= hum_next;
      tmp_reg <= tmp_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Open drain: only ever pulls low, clock is never stretched
  assign SCL_OUT = 1'b0;
  assign SCL_OE = 1'b0;
  assign SDA_OUT = 1'b0;
  assign SDA_OE = sda_oe_reg;
  assign READY = ready_reg;
  assign BUSY = busy_reg;
  assign MEASURE_START = start_reg;

endmodule : htr_readout

// >>> bench/htr_readout_asserts.sv
// Port checker of the readout target
`timescale 1ns/10ps
module htr_readout_asserts #(
  parameter int POWERUP_CYCLES = 20,
  parameter int MEAS_CYCLES = 50
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // Link and status
  input wire logic SCL_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  input wire logic READY,
  input wire logic BUSY,
  input wire logic MEASURE_START
);
  // Saturating, so a late READY still fails the window
  int rc_reg, rc_next, bc_reg, bc_next;
  always_comb begin
    rc_next = RESET ? 0 : rc_reg + int'(rc_reg < POWERUP_CYCLES + 4);
    bc_next = RESET ? 0 : MEASURE_START ? 1 : bc_reg + int'(BUSY);
  end
  always_ff @(posedge CLOCK) begin
    rc_reg <= rc_next;
    bc_reg <= bc_next;
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);
  a_sda_open_drain: assert property (SDA_OUT == 1'b0)
    else $error("SDA driven high");
  a_quiet_unready: assert property (!READY |-> !SDA_OE)
    else $error("ack before ready");
  a_ready_sticky: assert property (READY |=> READY)
    else $error("READY fell");
  a_ready_delay: assert property ($rose(READY) |->
    rc_reg inside {[POWERUP_CYCLES - 2:POWERUP_CYCLES + 2]}) else $error("READY delay");
  a_oe_after_fall: assert property ($changed(SDA_OE) |-> !$past(SCL_IN, 2))
    else $error("SDA moved with clock high");
  a_start_pulse: assert property (MEASURE_START |-> BUSY ##1 !MEASURE_START)
    else $error("start pulse wrong");
  a_busy_cause: assert property ($rose(BUSY) |-> MEASURE_START)
    else $error("busy without start");
  a_no_restart: assert property (MEASURE_START |-> !$past(BUSY))
    else $error("restart while busy");
  a_busy_length: assert property ($fell(BUSY) |->
    bc_reg inside {[MEAS_CYCLES - 1:MEAS_CYCLES + 1]}) else $error("busy length");
  c_meas: cover property (MEASURE_START);
  c_done: cover property ($fell(BUSY));
  c_ack: cover property ($rose(SDA_OE));
endmodule : htr_readout_asserts
bind htr_readout htr_readout_asserts #(.POWERUP_CYCLES(POWERUP_CYCLES), .MEAS_CYCLES(MEAS_CYCLES))
  htr_readout_asserts_inst (.CLOCK(CLOCK), .RESET(RESET), .SCL_IN(SCL_IN), .SDA_OUT(SDA_OUT),
  .SDA_OE(SDA_OE), .READY(READY), .BUSY(BUSY), .MEASURE_START(MEASURE_START));

// >>> bench/htr_host_model.sv
// Behavioural two-wire host on the link
`timescale 1ns/10ps
module htr_host_model (
  // Bench clock
  input wire logic clk,
  // Resolved lines
  input wire logic scl,
  input wire logic sda,
  // Pull-low requests, never a drive high
  output logic scl_low,
  output logic sda_low
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // Quarter of the 160 ns link period; clock stands high between frames
  task automatic qtr;
    repeat (10) @(negedge clk);
  endtask : qtr
  task automatic start;
    sda_low = 1'b0;
    qtr();
    scl_low = 1'b0;
    qtr();
    sda_low = 1'b1;
    qtr();
    scl_low = 1'b1;
    qtr();
  endtask : start
  task automatic stop;
    sda_low = 1'b1;
    qtr();
    scl_low = 1'b0;
    qtr();
    sda_low = 1'b0;
    qtr();
  endtask : stop
  // Data changes only while the clock is low
  task automatic bit1(input logic b, output logic r);
    sda_low = !b;
    qtr();
    scl_low = 1'b0;
    qtr();
    r = sda;
    qtr();
    scl_low = 1'b1;
    qtr();
  endtask : bit1
  // Ninth clock carries l from the host, or samples the target's ack
  task automatic xfer(input logic [7:0] d, input logic l,
    output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) bit1(d[i], q[i]);
    bit1(l, a);
  endtask : xfer
endmodule : htr_host_model

// >>> bench/test_htr_readout.sv
// Self-checking bench of the readout target
`timescale 1ns/10ps
module test_htr_readout;
  logic CLOCK = 1'b0;
  logic RESET = 1'b1;
  logic CALIBRATED = 1'b0;
  logic [19:0] HUMIDITY_RAW = '0;
  logic [19:0] TEMPERATURE_RAW = '0;
  logic SCL_OUT, SCL_OE, SDA_OUT, SDA_OE, READY, BUSY, MEASURE_START, scl_low, sda_low;
  logic [19:0] h, t;
  logic [7:0] q, exp_b[8], got[8];
  logic a;
  int n_errors = 0;
  int n_checks = 0;
  int seed = 9527;
  // Open-drain lines with pull-ups
  wire scl = !(scl_low || (SCL_OE && !SCL_OUT));
  wire sda = !(sda_low || (SDA_OE && !SDA_OUT));
  always #2 CLOCK = ~CLOCK;
  // Short counts keep the run small
  htr_readout #(.POWERUP_CYCLES(20), .MEAS_CYCLES(6000)) htr_readout_inst (
    .CLOCK(CLOCK), .RESET(RESET), .SCL_IN(scl), .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE),
    .SDA_IN(sda), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .HUMIDITY_RAW(HUMIDITY_RAW),
    .TEMPERATURE_RAW(TEMPERATURE_RAW), .CALIBRATED(CALIBRATED), .READY(READY),
    .BUSY(BUSY), .MEASURE_START(MEASURE_START));
  htr_host_model htr_host_model_inst (
    .clk(CLOCK), .scl(scl), .sda(sda), .scl_low(scl_low), .sda_low(sda_low));
  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    n_checks++;
    if (seen !== want) begin
      n_errors++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask : chk
  task automatic end_sim;
    if (n_errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim
  // Expected read bytes from the latched raw values
  function automatic void mk(input logic busy);
    logic [7:0] c;
    exp_b[0] = {busy, 3'b000, CALIBRATED, 3'b000};
    exp_b[1] = h[19:12];
    exp_b[2] = h[11:4];
    exp_b[3] = {h[3:0], t[19:16]};
    exp_b[4] = t[15:8];
    exp_b[5] = t[7:0];
    c = 8'hFF;
    for (int i = 0; i < 6; i++) begin
      c ^= exp_b[i];
      repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ 8'h31 : {c[6:0], 1'b0};
    end
    exp_b[6] = c;
    exp_b[7] = 8'hFF;
  endfunction : mk
  // Host-side scaling; an int holds 20 bits times 200 with room to spare
  function automatic int rh_pct(input logic [19:0] s);
    return (int'(s) * 100) >> 20;
  endfunction : rh_pct
  function automatic int t_deg(input logic [19:0] s);
    return ((int'(s) * 200) >> 20) - 50;
  endfunction : t_deg
  // ----------------------------------------
  // Link transfers
  // ----------------------------------------
  task automatic adr(input logic [7:0] b, input logic want);
    htr_host_model_inst.start();
    htr_host_model_inst.xfer(b, 1'b1, q, a);
    chk(8'(a), 8'(want));
  endtask : adr
  task automatic wr(input logic [7:0] b);
    htr_host_model_inst.xfer(b, 1'b1, q, a);
    chk(8'(a), 8'h00);
  endtask : wr
  task automatic rd(input int n);
    adr({7'h38, 1'b1}, 1'b0);
    for (int i = 0; i < n; i++) begin
      htr_host_model_inst.xfer(8'hFF, i == n - 1, q, a);
      got[i] = q;
      chk(q, exp_b[i]);
    end
    htr_host_model_inst.stop();
  endtask : rd
  task automatic trig;
    adr({7'h38, 1'b0}, 1'b0);
    wr(8'hAC);
    wr(8'h33);
    wr(8'h00);
    htr_host_model_inst.stop();
  endtask : trig
  initial begin
    repeat (4) @(negedge CLOCK);
    RESET = 1'b0;
    chk(8'(READY), 8'h00);
    repeat (25) @(negedge CLOCK);
    chk(8'(READY), 8'h01);
    for (int i = 0; i < 3; i++) begin
      h = 20'($random(seed));
      adr({7'h38 ^ (h[6:0] | 7'h01), h[7]}, 1'b1);
      htr_host_model_inst.stop();
    end
    // Wrong second parameter must not start a conversion
    adr({7'h38, 1'b0}, 1'b0);
    wr(8'hAC);
    wr(8'h33);
    wr(8'h01);
    htr_host_model_inst.stop();
    chk(8'(BUSY), 8'h00);
    // Round 0 uses extreme raw values; round 1 retriggers while busy
    for (int r = 0; r < 3; r++) begin
      h = (r == 0) ? 20'hF_FFFF : 20'($random(seed));
      t = (r == 0) ? 20'h0_0000 : 20'($random(seed));
      CALIBRATED = 1'($random(seed));
      HUMIDITY_RAW = h;
      TEMPERATURE_RAW = t;
      mk(1'b0);
      rd(1);
      if (r == 0) chk(got[0] & 8'h18, {4'h0, CALIBRATED, 3'h0});
      repeat (r == 1 ? 2 : 1) trig();
      chk(8'(BUSY), 8'h01);
      mk(1'b1);
      rd(1);
      for (int w = 0; w < 9000 && BUSY === 1'b1; w++) @(negedge CLOCK);
      chk(8'(BUSY), 8'h00);
      if (BUSY !== 1'b0) end_sim();
      // Inputs move after the latch, so reads must show the old values
      HUMIDITY_RAW = 20'($random(seed));
      TEMPERATURE_RAW = ~TEMPERATURE_RAW;
      mk(1'b0);
      rd(r == 0 ? 8 : 5 + r);
      chk(8'(rh_pct({got[1], got[2], got[3][7:4]})), 8'(rh_pct(h)));
      chk(8'(t_deg({got[3][3:0], got[4], got[5]})), 8'(t_deg(t)));
    end
    end_sim();
  end
endmodule : test_htr_readout
